/* File: common/prz_map.vh */
// prz_map.vh: register offsets, control fields, reset values, fixed-point constants
// assumes 16.16 fixed point and an apb slave with 32-bit data
`ifndef PRZ_MAP_VH
`define PRZ_MAP_VH
`define PRZ_A_CTRL 8'h00
`define PRZ_A_SIZE 8'h04
`define PRZ_A_SMIN 8'h08
`define PRZ_A_SMAX 8'h0c
`define PRZ_A_ATTA 8'h10
`define PRZ_A_ATTB 8'h14
`define PRZ_A_ATTC 8'h18
`define PRZ_A_FTHR 8'h1c
`define PRZ_A_STAT 8'h20
`define PRZ_A_DERV 8'h24
`define PRZ_A_WIDTH 8'h28
`define PRZ_B_AA 0
`define PRZ_B_SPR 1
`define PRZ_B_SHSZ 2
`define PRZ_B_MS 3
`define PRZ_B_FADE 4
`define PRZ_B_ORIG 5
`define PRZ_B_REPL 8
`define PRZ_NSETS 2
`define PRZ_TEXW 256
`define PRZ_CTRL_MASK 10'h33f
`define PRZ_CTRL_RST 10'h020
`define PRZ_ONE 32'h00010000
`define PRZ_HALF 32'h00008000
`define PRZ_FADE_ONE 17'h10000
`define PRZ_IMPL_MIN 32'h00002000
`define PRZ_IMPL_MAX 32'h00200000
`define PRZ_GRAD 32'h00002000
`define PRZ_MAX_NAA 16'h0020
`define PRZ_DIV_STEPS 7'h40
`endif

/* File: design/prz_isqrt.v */
// prz_isqrt.v: bit-serial integer square root, 32 result bits, one bit per cycle
// assumes start is a one-cycle pulse while not busy
`timescale 1ns/1ps
`default_nettype none
module prz_isqrt (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// request
	input wire start,
	input wire [63:0] rad,
	// answer
	output wire done,
	output wire [31:0] root
);
reg [63:0] rad_reg;
reg [31:0] res_reg;
reg [4:0] bit_reg;
reg busy_reg;
reg done_reg;
wire [31:0] trial = res_reg | (32'h1 << bit_reg);
wire [63:0] tsq = trial * trial;

assign done = done_reg;
assign root = res_reg;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		rad_reg <= 64'h0;
		res_reg <= 32'h0;
		bit_reg <= 5'h0;
		busy_reg <= 1'b0;
		done_reg <= 1'b0;
	end else begin
		done_reg <= 1'b0;
		if (start) begin
			rad_reg <= rad;
			res_reg <= 32'h0;
			bit_reg <= 5'h1f;
			busy_reg <= 1'b1;
		end else if (busy_reg) begin
			if (tsq <= rad_reg)
				res_reg <= trial;
			if (bit_reg == 5'h0) begin
				busy_reg <= 1'b0;
				done_reg <= 1'b1;
			end else
				bit_reg <= bit_reg - 5'h1;
		end
	end
end
endmodule // prz_isqrt
`default_nettype wire

/* File: design/prz_point_raster.v */
// prz_point_raster.v: point size derivation and point rasterizer with apb registers
// assumes one clock, 16.16 fixed point, points in and fragments out by valid/ready
//
// What this block does
// [RULE_01] size register resets to 1.0; writes of zero or below rejected, error flagged
// [RULE_02] attenuated size is size*sqrt(1/(a+b*d+c*d*d)), clamped min/max then range
// [RULE_03] without multisampling the derived size is the raster width
// [RULE_04] shader sizing takes shader size, range clamp only; else programmed size
// [RULE_05] multisample fade: width held at threshold, fade is (size/threshold) squared
// [RULE_06] negative minimum, maximum or threshold writes rejected with error flag
// [RULE_07] antialias and sprite enables reset off; sprites override antialias
// [RULE_08] one replacement flag per texture set, all reset false
// [RULE_09] sprite origin is lower-left or upper-left, resets upper-left
// [RULE_10] default state truncates x and y and emits one fragment
// [RULE_11] plain points round width, clamp to largest width, zero becomes one
// [RULE_12] largest plain width at least rounded largest antialias width, at least one
// [RULE_13] odd width centres on floor plus half, odd square grid
// [RULE_14] even width centres on floor(x+1/2), all centres in even square
// [RULE_15] plain point fragments carry the vertex data unchanged
// [RULE_16] antialias emits squares touching circle, coverage from intersection area
// [RULE_17] antialias widths snap to nearest even gradation, 1.0 included
// [RULE_18] sprites emit pixels whose centre lies inside the square
// [RULE_19] sprites carry sprite coordinate; flagged sets get sprite coordinates
// [RULE_20] s and t from centre offset over size, t sign by origin
// [RULE_21] replaced sets get r forced to 0 and q to 1
// [RULE_22] sprite widths snap to nearest supported width, superset of antialias
// [RULE_23] 16.16 fixed point; one point per handshake; fragments under valid/ready
`timescale 1ns/1ps
`default_nettype none
`include "prz_map.vh"
module prz_point_raster (
	// apb slave
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// point from vertex stage
	input wire pt_valid,
	output wire pt_ready,
	input wire [31:0] pt_xw,
	input wire [31:0] pt_yw,
	input wire [31:0] pt_eye_dist,
	input wire [31:0] shader_size_output,
	input wire pt_shader_active,
	input wire [31:0] pt_color,
	input wire [`PRZ_TEXW-1:0] pt_tex,
	// fragments to per-fragment stage
	output wire frag_valid,
	input wire frag_ready,
	output wire [15:0] frag_x,
	output wire [15:0] frag_y,
	output wire [4:0] frag_cov,
	output wire [16:0] frag_fade,
	output wire [31:0] frag_color,
	output wire [`PRZ_TEXW-1:0] frag_tex,
	output wire [31:0] sprite_coord_output_s,
	output wire [31:0] sprite_coord_output_t
);
localparam [9:0] S_IDLE = 10'h001;
localparam [9:0] S_CALC = 10'h002;
localparam [9:0] S_DIV = 10'h004;
localparam [9:0] S_SQRT = 10'h008;
localparam [9:0] S_CLAMP = 10'h010;
localparam [9:0] S_FDIV = 10'h020;
localparam [9:0] S_WIDTH = 10'h040;
localparam [9:0] S_IDIV = 10'h080;
localparam [9:0] S_SETUP = 10'h100;
localparam [9:0] S_SCAN = 10'h200;

////////////////////////////////////////////////////////////////////////////////
// arithmetic helpers

function [31:0] fxm;
	input [31:0] a;
	input [31:0] b;
	reg [63:0] p;
	begin
		p = a * b;
		fxm = (p[63:48] != 16'h0) ? 32'hffffffff : p[47:16];
	end
endfunction

function [63:0] sq;
	input [31:0] v;
	reg [31:0] a;
	begin
		a = v[31] ? (~v + 32'h1) : v;
		sq = a * a;
	end
endfunction

function [31:0] smul;
	input [31:0] d;
	input [31:0] k;
	reg [31:0] a;
	reg [63:0] p;
	begin
		a = d[31] ? (~d + 32'h1) : d;
		p = a * k;
		smul = d[31] ? (~p[47:16] + 32'h1) : p[47:16];
	end
endfunction

function [31:0] clampu;
	input [31:0] v;
	input [31:0] lo;
	input [31:0] hi;
	begin
		clampu = (v < lo) ? lo : ((v > hi) ? hi : v);
	end
endfunction

// {first, last} pixel index along one axis
function [31:0] span;
	input [31:0] c;
	input [31:0] w;
	input naa;
	reg [31:0] r;
	reg [15:0] m;
	reg [15:0] nh;
	begin
		r = c + `PRZ_HALF;
		m = w[16] ? c[31:16] : r[31:16]; // RULE_13
		nh = {1'b0, w[31:17]};
		if (naa) begin
			span = {m - nh, m + nh - {15'h0, ~w[16]}}; // RULE_14
		end else begin
			r = c - {1'b0, w[31:1]};
			span[31:16] = r[31:16];
			r = c + {1'b0, w[31:1]};
			span[15:0] = r[31:16];
		end
	end
endfunction

// distance from centre to nearest point of one pixel edge pair
function [31:0] near;
	input [15:0] p;
	input [31:0] c;
	reg [31:0] lo;
	reg [31:0] hi;
	begin
		lo = {p, 16'h0};
		hi = lo + `PRZ_ONE;
		if ($signed(c) < $signed(lo))
			near = lo - c;
		else if ($signed(c) > $signed(hi))
			near = c - hi;
		else
			near = 32'h0;
	end
endfunction

// 4x4 sample estimate of circle area over one pixel square
function [4:0] covn;
	input [15:0] px;
	input [15:0] py;
	input [31:0] xw;
	input [31:0] yw;
	input [63:0] r2;
	integer i;
	integer j;
	reg [31:0] sx;
	reg [31:0] sy;
	begin
		covn = 5'h0;
		for (i = 0; i < 4; i = i + 1) begin
			for (j = 0; j < 4; j = j + 1) begin
				sx = {px, 16'h0} + 32'h2000 + (i << 14);
				sy = {py, 16'h0} + 32'h2000 + (j << 14);
				if (sq(sx - xw) + sq(sy - yw) < r2)
					covn = covn + 5'h1;
			end
		end
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers

reg [9:0] ctrl_reg;
reg [31:0] size_reg;
reg [31:0] smin_reg;
reg [31:0] smax_reg;
reg [31:0] atta_reg;
reg [31:0] attb_reg;
reg [31:0] attc_reg;
reg [31:0] fthr_reg;
reg err_reg;
reg [9:0] st_reg;
reg [31:0] derived_reg;
reg [31:0] wq_reg;
wire wr_en = psel & penable & pwrite;
wire map_hit = (paddr[1:0] == 2'b00) && (paddr <= `PRZ_A_WIDTH);
wire neg = pwdata[31];
wire bad_size = neg | (pwdata == 32'h0);

assign pready = 1'b1;
assign pslverr = psel & penable & ~map_hit;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		ctrl_reg <= `PRZ_CTRL_RST; // RULE_07 RULE_08 RULE_09
		size_reg <= `PRZ_ONE; // RULE_01
		smin_reg <= 32'h0;
		smax_reg <= `PRZ_IMPL_MAX;
		atta_reg <= `PRZ_ONE;
		attb_reg <= 32'h0;
		attc_reg <= 32'h0;
		fthr_reg <= `PRZ_ONE;
		err_reg <= 1'b0;
	end else begin
		if (wr_en) begin
			if (paddr == `PRZ_A_CTRL)
				ctrl_reg <= pwdata[9:0] & `PRZ_CTRL_MASK;
			else if (paddr == `PRZ_A_SIZE && !bad_size)
				size_reg <= pwdata; // RULE_01
			else if (paddr == `PRZ_A_SMIN && !neg)
				smin_reg <= pwdata; // RULE_06
			else if (paddr == `PRZ_A_SMAX && !neg)
				smax_reg <= pwdata; // RULE_06
			else if (paddr == `PRZ_A_ATTA)
				atta_reg <= pwdata;
			else if (paddr == `PRZ_A_ATTB)
				attb_reg <= pwdata;
			else if (paddr == `PRZ_A_ATTC)
				attc_reg <= pwdata;
			else if (paddr == `PRZ_A_FTHR && !neg)
				fthr_reg <= pwdata; // RULE_06
			else if (paddr == `PRZ_A_STAT && pwdata[0])
				err_reg <= 1'b0;
		end
		// set wins over a clear in the same cycle
		if (wr_en && ((paddr == `PRZ_A_SIZE && bad_size) || (neg &&
			(paddr == `PRZ_A_SMIN || paddr == `PRZ_A_SMAX || paddr == `PRZ_A_FTHR))))
			err_reg <= 1'b1; // RULE_01 RULE_06
	end
end

always @* begin
	prdata = 32'h0;
	if (paddr == `PRZ_A_CTRL)
		prdata = {22'h0, ctrl_reg};
	else if (paddr == `PRZ_A_SIZE)
		prdata = size_reg;
	else if (paddr == `PRZ_A_SMIN)
		prdata = smin_reg;
	else if (paddr == `PRZ_A_SMAX)
		prdata = smax_reg;
	else if (paddr == `PRZ_A_ATTA)
		prdata = atta_reg;
	else if (paddr == `PRZ_A_ATTB)
		prdata = attb_reg;
	else if (paddr == `PRZ_A_ATTC)
		prdata = attc_reg;
	else if (paddr == `PRZ_A_FTHR)
		prdata = fthr_reg;
	else if (paddr == `PRZ_A_STAT)
		prdata = {30'h0, (st_reg != S_IDLE), err_reg};
	else if (paddr == `PRZ_A_DERV)
		prdata = derived_reg;
	else if (paddr == `PRZ_A_WIDTH)
		prdata = wq_reg;
end

////////////////////////////////////////////////////////////////////////////////
// point state and size pipeline

reg [9:0] pc_reg;
reg [31:0] xw_reg;
reg [31:0] yw_reg;
reg [31:0] dist_reg;
reg [31:0] shsz_reg;
reg shact_reg;
reg [31:0] col_reg;
reg [`PRZ_TEXW-1:0] tex_reg;
reg [31:0] raw_reg;
reg nocl_reg;
reg [31:0] width_reg;
reg [16:0] fade_reg;
reg [31:0] inv_reg;
reg [63:0] dn_reg;
reg [31:0] dd_reg;
reg [32:0] dr_reg;
reg [6:0] dc_reg;
reg sq_go_reg;
reg [63:0] sq_rad_reg;
reg [15:0] x0_reg;
reg [15:0] x1_reg;
reg [15:0] y1_reg;
reg [15:0] px_reg;
reg [15:0] py_reg;
wire sq_done;
wire [31:0] sq_root;
wire emit;
wire free;

prz_isqrt u_sqrt (
	.pclk(pclk),
	.presetn(presetn),
	.start(sq_go_reg),
	.rad(sq_rad_reg),
	.done(sq_done),
	.root(sq_root)
);

wire naa = ~pc_reg[`PRZ_B_AA] & ~pc_reg[`PRZ_B_SPR];
wire spr = pc_reg[`PRZ_B_SPR];
wire [31:0] d2 = fxm(dist_reg, dist_reg);
wire [33:0] qsum = {2'b0, atta_reg} + {2'b0, fxm(attb_reg, dist_reg)} +
	{2'b0, fxm(attc_reg, d2)};
wire [31:0] qv = (qsum[33:32] != 2'b0) ? 32'hffffffff : qsum[31:0];
wire [63:0] sz2 = size_reg * size_reg;
wire [32:0] dsh = {dr_reg[31:0], dn_reg[63]};
wire dge = dsh >= {1'b0, dd_reg};
wire [32:0] dsub = dsh - {1'b0, dd_reg};
wire [31:0] dc1 = nocl_reg ? raw_reg : clampu(raw_reg, smin_reg, smax_reg);
wire [31:0] dv = clampu(dc1, `PRZ_IMPL_MIN, `PRZ_IMPL_MAX);
wire [31:0] wr = width_reg + `PRZ_HALF;
wire [15:0] wn = (wr[31:16] == 16'h0) ? 16'h1 :
	((wr[31:16] > `PRZ_MAX_NAA) ? `PRZ_MAX_NAA : wr[31:16]); // RULE_11 RULE_12
wire [31:0] wg0 = (width_reg + (`PRZ_GRAD >> 1)) & ~(`PRZ_GRAD - 32'h1);
wire [31:0] wg = clampu(wg0, `PRZ_GRAD, `PRZ_IMPL_MAX); // RULE_17 RULE_22
wire [31:0] wq_n = naa ? {wn, 16'h0} : wg;
wire [31:0] fsq = fxm(dn_reg[31:0], dn_reg[31:0]);
wire [31:0] spx = span(xw_reg, wq_reg, naa);
wire [31:0] spy = span(yw_reg, wq_reg, naa);

assign pt_ready = (st_reg == S_IDLE); // RULE_23

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		st_reg <= S_IDLE;
		pc_reg <= 10'h0;
		xw_reg <= 32'h0;
		yw_reg <= 32'h0;
		dist_reg <= 32'h0;
		shsz_reg <= 32'h0;
		shact_reg <= 1'b0;
		col_reg <= 32'h0;
		tex_reg <= {`PRZ_TEXW{1'b0}};
		raw_reg <= 32'h0;
		nocl_reg <= 1'b0;
		derived_reg <= 32'h0;
		width_reg <= 32'h0;
		fade_reg <= `PRZ_FADE_ONE;
		wq_reg <= 32'h0;
		inv_reg <= 32'h0;
		dn_reg <= 64'h0;
		dd_reg <= 32'h1;
		dr_reg <= 33'h0;
		dc_reg <= 7'h0;
		sq_go_reg <= 1'b0;
		sq_rad_reg <= 64'h0;
		x0_reg <= 16'h0;
		x1_reg <= 16'h0;
		y1_reg <= 16'h0;
		px_reg <= 16'h0;
		py_reg <= 16'h0;
	end else begin
		sq_go_reg <= 1'b0;
		if (dc_reg != 7'h0) begin
			dc_reg <= dc_reg - 7'h1;
			dr_reg <= dge ? dsub : dsh;
			dn_reg <= {dn_reg[62:0], dge};
		end
		case (st_reg)
		S_IDLE: begin
			if (pt_valid) begin // RULE_23
				pc_reg <= ctrl_reg;
				xw_reg <= pt_xw;
				yw_reg <= pt_yw;
				dist_reg <= pt_eye_dist;
				shsz_reg <= shader_size_output;
				shact_reg <= pt_shader_active;
				col_reg <= pt_color;
				tex_reg <= pt_tex;
				st_reg <= S_CALC;
			end
		end
		S_CALC: begin
			if (shact_reg && pc_reg[`PRZ_B_SHSZ]) begin
				raw_reg <= shsz_reg; // RULE_04
				nocl_reg <= 1'b1;
				st_reg <= S_CLAMP;
			end else if (shact_reg) begin
				raw_reg <= size_reg; // RULE_04
				nocl_reg <= 1'b0;
				st_reg <= S_CLAMP;
			end else begin
				nocl_reg <= 1'b0;
				dn_reg <= {sz2[63:16], 16'h0}; // RULE_02
				dd_reg <= (qv == 32'h0) ? 32'h1 : qv;
				dr_reg <= 33'h0;
				dc_reg <= `PRZ_DIV_STEPS;
				st_reg <= S_DIV;
			end
		end
		S_DIV: begin
			if (dc_reg == 7'h0) begin
				sq_rad_reg <= (dn_reg[63:48] != 16'h0) ? 64'hffffffffffffffff :
					{dn_reg[47:0], 16'h0}; // RULE_02
				sq_go_reg <= 1'b1;
				st_reg <= S_SQRT;
			end
		end
		S_SQRT: begin
			if (sq_done) begin
				raw_reg <= sq_root;
				st_reg <= S_CLAMP;
			end
		end
		S_CLAMP: begin
			derived_reg <= dv; // RULE_02
			if (pc_reg[`PRZ_B_MS] && pc_reg[`PRZ_B_FADE] && dv < fthr_reg) begin
				width_reg <= clampu(fthr_reg, `PRZ_IMPL_MIN, `PRZ_IMPL_MAX); // RULE_05
				dn_reg <= {16'h0, dv, 16'h0};
				dd_reg <= fthr_reg;
				dr_reg <= 33'h0;
				dc_reg <= `PRZ_DIV_STEPS;
				st_reg <= S_FDIV;
			end else begin
				width_reg <= dv; // RULE_03
				fade_reg <= `PRZ_FADE_ONE; // RULE_05
				st_reg <= S_WIDTH;
			end
		end
		S_FDIV: begin
			if (dc_reg == 7'h0) begin
				fade_reg <= fsq[16:0]; // RULE_05
				st_reg <= S_WIDTH;
			end
		end
		S_WIDTH: begin
			wq_reg <= wq_n;
			dn_reg <= 64'h0000000100000000;
			dd_reg <= wq_n;
			dr_reg <= 33'h0;
			dc_reg <= `PRZ_DIV_STEPS;
			st_reg <= S_IDIV;
		end
		S_IDIV: begin
			if (dc_reg == 7'h0) begin
				inv_reg <= dn_reg[31:0];
				st_reg <= S_SETUP;
			end
		end
		S_SETUP: begin
			x0_reg <= spx[31:16]; // RULE_10 RULE_13 RULE_14
			x1_reg <= spx[15:0];
			y1_reg <= spy[15:0];
			px_reg <= spx[31:16];
			py_reg <= spy[31:16];
			st_reg <= S_SCAN;
		end
		S_SCAN: begin
			if (free) begin
				if (px_reg == x1_reg) begin
					px_reg <= x0_reg;
					if (py_reg == y1_reg)
						st_reg <= S_IDLE;
					else
						py_reg <= py_reg + 16'h1;
				end else
					px_reg <= px_reg + 16'h1;
			end
		end
		default: st_reg <= S_IDLE;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// per-pixel test and fragment output stage

reg fv_reg;
reg [15:0] fx_reg;
reg [15:0] fy_reg;
reg [4:0] fc_reg;
reg [16:0] ff_reg;
reg [31:0] fcol_reg;
reg [`PRZ_TEXW-1:0] ftex_reg;
reg [31:0] fs_reg;
reg [31:0] ft_reg;
reg [`PRZ_TEXW-1:0] tex_n;
reg hit;
reg [4:0] cov;
integer k;
wire [31:0] dx = {px_reg, 16'h8000} - xw_reg;
wire [31:0] dy = {py_reg, 16'h8000} - yw_reg;
wire [31:0] hw = {1'b0, wq_reg[31:1]};
wire [63:0] hsq = sq(hw);
wire [31:0] tt = smul(dy, inv_reg);
wire [31:0] s_val = `PRZ_HALF + smul(dx, inv_reg); // RULE_20
wire [31:0] t_val = pc_reg[`PRZ_B_ORIG] ? (`PRZ_HALF - tt) : (`PRZ_HALF + tt); // RULE_20

assign free = ~fv_reg | frag_ready;
assign emit = (st_reg == S_SCAN) & free & hit;

always @* begin
	hit = 1'b1;
	cov = 5'h10;
	if (spr) begin
		hit = (sq(dx) < hsq) && (sq(dy) < hsq); // RULE_07 RULE_18
	end else if (!naa) begin
		hit = (sq(near(px_reg, xw_reg)) + sq(near(py_reg, yw_reg))) < hsq; // RULE_16
		cov = covn(px_reg, py_reg, xw_reg, yw_reg, hsq); // RULE_16
	end
end

always @* begin
	tex_n = tex_reg; // RULE_15
	for (k = 0; k < `PRZ_NSETS; k = k + 1) begin
		if (spr && pc_reg[`PRZ_B_REPL + k])
			tex_n[k*128 +: 128] = {`PRZ_ONE, 32'h0, t_val, s_val}; // RULE_19 RULE_21
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		fv_reg <= 1'b0;
		fx_reg <= 16'h0;
		fy_reg <= 16'h0;
		fc_reg <= 5'h0;
		ff_reg <= 17'h0;
		fcol_reg <= 32'h0;
		ftex_reg <= {`PRZ_TEXW{1'b0}};
		fs_reg <= 32'h0;
		ft_reg <= 32'h0;
	end else if (emit) begin
		fv_reg <= 1'b1; // RULE_23
		fx_reg <= px_reg;
		fy_reg <= py_reg;
		fc_reg <= cov;
		ff_reg <= fade_reg;
		fcol_reg <= col_reg; // RULE_15
		ftex_reg <= tex_n;
		fs_reg <= spr ? s_val : 32'h0; // RULE_19
		ft_reg <= spr ? t_val : 32'h0;
	end else if (frag_ready) begin
		fv_reg <= 1'b0;
	end
end

assign frag_valid = fv_reg;
assign frag_x = fx_reg;
assign frag_y = fy_reg;
assign frag_cov = fc_reg;
assign frag_fade = ff_reg;
assign frag_color = fcol_reg;
assign frag_tex = ftex_reg;
assign sprite_coord_output_s = fs_reg;
assign sprite_coord_output_t = ft_reg;

endmodule // prz_point_raster
`default_nettype wire

/* File: tb/prz_frag_sink.sv */
// prz_frag_sink.sv: per-fragment stage model, records every fragment taken
// assumes stall_en makes ready toggle every cycle
`timescale 1ns/1ps
`default_nettype none
module prz_frag_sink (
	// clock, reset, control
	input wire logic pclk,
	input wire logic presetn,
	input wire logic stall_en,
	// fragment stream
	input wire logic frag_valid,
	output logic frag_ready,
	input wire logic [15:0] frag_x,
	input wire logic [15:0] frag_y,
	input wire logic [4:0] frag_cov,
	input wire logic [16:0] frag_fade,
	input wire logic [31:0] frag_color,
	input wire logic [255:0] frag_tex,
	input wire logic [31:0] spr_s,
	input wire logic [31:0] spr_t
);
	logic [255:0] fx[$], fy[$], fc[$], ff[$], fk[$], fq[$], fs[$], ft[$];
	logic tog_reg;
	// one fragment taken per edge with valid and ready
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frag_ready <= 1'b0;
			tog_reg <= 1'b0;
		end else begin
			tog_reg <= ~tog_reg;
			frag_ready <= !stall_en || tog_reg;
			if (frag_valid && frag_ready) begin
				fx.push_back(256'(frag_x));
				fy.push_back(256'(frag_y));
				fc.push_back(256'(frag_cov));
				ff.push_back(256'(frag_fade));
				fk.push_back(256'(frag_color));
				fq.push_back(frag_tex);
				fs.push_back(256'(spr_s));
				ft.push_back(256'(spr_t));
			end
		end
	end
endmodule // prz_frag_sink
`default_nettype wire

/* File: tb/prz_point_raster_assertions.sv */
// prz_point_raster_assertions.sv: port checker for the point rasterizer
// assumes one pclk domain and control written only while no point is in flight
`timescale 1ns/1ps
`default_nettype none
module prz_point_raster_chk (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// point and fragments
	input wire logic pt_valid,
	input wire logic pt_ready,
	input wire logic [31:0] pt_color,
	input wire logic frag_valid,
	input wire logic frag_ready,
	input wire logic [15:0] frag_x,
	input wire logic [4:0] frag_cov,
	input wire logic [16:0] frag_fade,
	input wire logic [31:0] frag_color,
	input wire logic [31:0] sprite_coord_output_s
);
	logic [3:0] ctl_reg;
	logic [31:0] col_reg;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	//////////////////////////////////////////////////////////////////////
	// shadow of control bits and point data
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_reg <= 4'h0;
			col_reg <= 32'h0;
		end else begin
			if (psel && penable && pwrite && paddr == 8'h00)
				ctl_reg <= pwdata[3:0];
			if (pt_valid && pt_ready)
				col_reg <= pt_color;
		end
	end
	//////////////////////////////////////////////////////////////////////
	unmapped_err_a: assert property (psel && penable && (paddr > 8'h28 || paddr[1:0] != 2'h0)
		|-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
	mapped_ok_a: assert property (psel && penable && paddr <= 8'h28 && paddr[1:0] == 2'h0
		|-> pready && !pslverr) else $error("mapped access refused");
	accept_busy_a: assert property (pt_valid && pt_ready |=> !pt_ready [*8])
		else $error("point accepted while busy");
	frag_hold_a: assert property (frag_valid && !frag_ready |=> frag_valid && $stable(frag_x)
		&& $stable(frag_color) && $stable(frag_fade)) else $error("fragment changed while stalled");
	same_data_a: assert property (frag_valid |-> frag_color == col_reg)
		else $error("fragment data differs from vertex");
	full_cov_a: assert property (frag_valid && (!ctl_reg[0] || ctl_reg[1]) |-> frag_cov == 5'h10)
		else $error("non-antialiased coverage not full");
	spr_zero_a: assert property (frag_valid && !ctl_reg[1] |-> sprite_coord_output_s == 32'h0)
		else $error("sprite coordinate outside sprite mode");
	fade_one_a: assert property (frag_valid && !ctl_reg[3] |-> frag_fade == 17'h10000)
		else $error("fade applied without multisampling");
endmodule // prz_point_raster_chk
bind prz_point_raster prz_point_raster_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .pt_valid, .pt_ready, .pt_color, .frag_valid,
	.frag_ready, .frag_x, .frag_cov, .frag_fade, .frag_color, .sprite_coord_output_s);
`default_nettype wire

/* File: tb/tb.sv */
// tb.sv: self-checking bench for the point rasterizer, apb tasks and point tasks
// assumes prz_map.vh on the include path and the fragment sink model
`timescale 1ns/1ps
`default_nettype none
`include "prz_map.vh"
module tb;
	localparam logic [31:0] CLR = 32'hc0de5a17;
	localparam logic [255:0] TEX = {8{32'h12345678}};
	localparam logic [31:0] PX = 32'h0028c000;
	localparam logic [31:0] PY = 32'h00144000;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic pt_valid = 0, pt_shader_active = 0, stall_en = 0, re;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, pt_xw = 0, pt_yw = 0, shader_size_output = 0, rv;
	logic [31:0] pt_color = 0, col = 0, pt_eye_dist = 32'h40000;
	wire pt_ready, pready, pslverr, frag_valid, frag_ready;
	wire [31:0] prdata, frag_color, spr_s, spr_t;
	wire [15:0] frag_x, frag_y;
	wire [4:0] frag_cov;
	wire [16:0] frag_fade;
	wire [`PRZ_TEXW-1:0] frag_tex;
	int fail_count = 0, cmp_count = 0, cyc = 0, b0 = 0;
	prz_point_raster u_prz_point_raster (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pt_valid(pt_valid), .pt_ready(pt_ready),
		.pt_xw(pt_xw), .pt_yw(pt_yw), .pt_eye_dist(pt_eye_dist),
		.shader_size_output(shader_size_output), .pt_shader_active(pt_shader_active),
		.pt_color(pt_color), .pt_tex(TEX), .frag_valid(frag_valid), .frag_ready(frag_ready),
		.frag_x(frag_x), .frag_y(frag_y), .frag_cov(frag_cov), .frag_fade(frag_fade),
		.frag_color(frag_color), .frag_tex(frag_tex), .sprite_coord_output_s(spr_s),
		.sprite_coord_output_t(spr_t));
	prz_frag_sink u_prz_frag_sink (.pclk(pclk), .presetn(presetn), .stall_en(stall_en),
		.frag_valid(frag_valid), .frag_ready(frag_ready), .frag_x(frag_x), .frag_y(frag_y),
		.frag_cov(frag_cov), .frag_fade(frag_fade), .frag_color(frag_color),
		.frag_tex(frag_tex), .spr_s(spr_s), .spr_t(spr_t));
	//////////////////////////////////////////////////////////////////////
	initial forever #12.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fail_count++;
			end_of_test;
		end
	end
	task end_of_test;
		$display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [255:0] g, input logic [255:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t: got %h exp %h", $time, g, e);
		end
	endtask
	// apb transfer, answer taken at the edge that samples pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rv, e);
	endtask
	// offer one point and wait until its fragments are all taken
	task pt(input logic [31:0] x, input logic [31:0] y, input logic [31:0] s, input logic a);
		b0 = u_prz_frag_sink.fx.size();
		col = CLR ^ 32'(b0);
		@(posedge pclk);
		pt_valid <= 1'b1;
		pt_xw <= x;
		pt_yw <= y;
		pt_color <= col;
		shader_size_output <= s;
		pt_shader_active <= a;
		do @(posedge pclk); while (pt_ready !== 1'b1);
		pt_valid <= 1'b0;
		do @(negedge pclk); while (!(pt_ready === 1'b1 && frag_valid === 1'b0));
	endtask
	// n by n square, raster order
	task sq(input int n, input int x0, input int y0);
		chk(u_prz_frag_sink.fx.size() - b0, n * n);
		for (int i = 0; i < n * n; i++) begin
			chk(u_prz_frag_sink.fx[b0 + i], x0 + i % n);
			chk(u_prz_frag_sink.fy[b0 + i], y0 + i / n);
			chk(u_prz_frag_sink.fk[b0 + i], col);
		end
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rdc(`PRZ_A_CTRL, 32'h20);
		rdc(`PRZ_A_SIZE, `PRZ_ONE);
		rdc(`PRZ_A_SMIN, 32'h0);
		rdc(`PRZ_A_SMAX, `PRZ_IMPL_MAX);
		rdc(`PRZ_A_FTHR, `PRZ_ONE);
		rdc(`PRZ_A_STAT, 32'h0);
		$display("reset values done");
		wr(`PRZ_A_SIZE, 32'h0);
		rdc(`PRZ_A_SIZE, `PRZ_ONE);
		rdc(`PRZ_A_STAT, 32'h1);
		for (int k = 0; k < 4; k++) begin
			wr(`PRZ_A_STAT, 32'h1);
			wr((k == 3) ? `PRZ_A_FTHR : 8'(4 * k + 4), 32'hffff0000);
			rdc(`PRZ_A_STAT, 32'h1);
		end
		rdc(`PRZ_A_SMIN, 32'h0);
		rdc(`PRZ_A_FTHR, `PRZ_ONE);
		apb(1'b0, 8'h2c, 32'h0);
		chk(re, 1'b1);
		wr(`PRZ_A_STAT, 32'h1);
		$display("refused writes done");
		pt(PX, PY, 32'h0, 1'b0);
		sq(1, 40, 20);
		chk(u_prz_frag_sink.fq[b0], TEX);
		rdc(`PRZ_A_DERV, `PRZ_ONE);
		wr(`PRZ_A_ATTA, 32'h0);
		wr(`PRZ_A_ATTB, `PRZ_ONE);
		pt_eye_dist <= 32'h100000;
		pt(PX, PY, 32'h0, 1'b0);
		rdc(`PRZ_A_DERV, 32'h4000);
		sq(1, 40, 20);
		wr(`PRZ_A_SMIN, 32'h20000);
		pt(PX, PY, 32'h0, 1'b0);
		rdc(`PRZ_A_DERV, 32'h20000);
		sq(2, 40, 19);
		wr(`PRZ_A_SIZE, 32'h30000);
		pt(PX, PY, `PRZ_ONE, 1'b1);
		sq(3, 39, 19);
		$display("size derivation done");
		wr(`PRZ_A_CTRL, 32'h24);
		stall_en <= 1'b1;
		pt(PX, PY, 32'h50000, 1'b1);
		sq(5, 38, 18);
		pt(PX, PY, 32'h4000, 1'b1);
		sq(1, 40, 20);
		pt(PX, PY, 32'h280000, 1'b1);
		rdc(`PRZ_A_DERV, `PRZ_IMPL_MAX);
		sq(32, 25, 4);
		$display("shader sizing done");
		for (int o = 0; o < 2; o++) begin
			wr(`PRZ_A_CTRL, 32'h107 | (o << 5));
			pt(32'h290000, 32'h140000, 32'h20000, 1'b1);
			sq(2, 40, 19);
			for (int i = 0; i < 4; i++) begin
				chk(u_prz_frag_sink.fc[b0 + i], 5'h10);
				chk(u_prz_frag_sink.fs[b0 + i], (i % 2) ? 32'hc000 : 32'h4000);
				chk(u_prz_frag_sink.ft[b0 + i], ((i / 2) != o) ? 32'hc000 : 32'h4000);
				chk(u_prz_frag_sink.fq[b0 + i], {TEX[255:128], `PRZ_ONE, 32'h0,
					(((i / 2) != o) ? 32'hc000 : 32'h4000), ((i % 2) ? 32'hc000 : 32'h4000)});
			end
		end
		$display("sprites done");
		wr(`PRZ_A_CTRL, 32'h5);
		pt(32'h290000, 32'h140000, 32'h20000, 1'b1);
		sq(2, 40, 19);
		for (int i = 0; i < 4; i++) begin
			chk(u_prz_frag_sink.fc[b0 + i], 5'hd);
		end
		rdc(`PRZ_A_WIDTH, 32'h20000);
		$display("antialias done");
		wr(`PRZ_A_CTRL, 32'h1c);
		wr(`PRZ_A_FTHR, 32'h40000);
		pt(32'h290000, 32'h140000, 32'h20000, 1'b1);
		sq(4, 39, 18);
		chk(u_prz_frag_sink.ff[b0], 17'h4000);
		rdc(`PRZ_A_DERV, 32'h20000);
		$display("fade done");
		end_of_test;
	end
endmodule // tb
`default_nettype wire
